// >>> hw/mbwch_cfg.svh
// constants of the write command handler
`ifndef MBWCH_CFG_SVH
`define MBWCH_CFG_SVH
`define MBWCH_FC_WR_SINGLE 8'h06
`define MBWCH_FC_WR_COILS 8'h0f
`define MBWCH_FC_WR_REGS 8'h10
`define MBWCH_EXC_FLAG 8'h80
`define MBWCH_EXC_FUNC 8'h01
`define MBWCH_EXC_ADDR 8'h02
`define MBWCH_EXC_VALUE 8'h03
`define MBWCH_EXC_NONE 8'h00
`define MBWCH_BROADCAST 8'h00
`define MBWCH_MAX_REGS 16'h007b
`define MBWCH_MAX_COILS 16'h07b0
`define MBWCH_COIL_COUNT 17'h00020
`define MBWCH_COIL_RSVD_MASK 32'h8000_0200
`define MBWCH_POS_FWD 5'h00
`define MBWCH_POS_STOP 5'h0a
`define MBWCH_POS_SERVO 5'h0c
`define MBWCH_ADDR_INERTIA 16'h2100
`define MBWCH_ADDR_JOG 16'h2300
`define MBWCH_ADDR_ACCEL 16'h2301
`define MBWCH_ADDR_DECEL 16'h2302
`define MBWCH_PARAM_RESET 16'h0000
`define MBWCH_SINGLE_DATA_POS 9'h004
`define MBWCH_MULTI_DATA_POS 9'h007
`define MBWCH_SINGLE_FRAME_LEN 9'h006
`define MBWCH_SINGLE_DATA_LEN 9'h002
`define MBWCH_ACK_LEN 3'h6
`define MBWCH_EXC_LEN 3'h3
`define MBWCH_BUF_DEPTH 246
`endif

// >>> hw/mbwch_pkg.sv
// types shared by the write command handler
`default_nettype none
package mbwch_pkg;
  typedef enum logic [1:0] {
    MBWCH_ST_RECV,
    MBWCH_ST_CHECK,
    MBWCH_ST_COMMIT,
    MBWCH_ST_REPLY
  } mbwch_state_type;
endpackage : mbwch_pkg
`default_nettype wire

// >>> hw/mbwch_param_reg.sv
// one 16-bit parameter register with its own address match
`timescale 1ns/1ns
`default_nettype none
`include "mbwch_cfg.svh"
module mbwch_param_reg #(
  parameter logic [15:0] ADDR = 16'h0000
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic [15:0] data_i,
  output logic hit_o,
  output logic signed [15:0] value_o
);
  // address match, used both to check and to write
  assign hit_o = (addr_i == ADDR);

  // stored word, taken as a signed quantity
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      value_o <= `MBWCH_PARAM_RESET;
    end else if (wr_i && hit_o) begin
      value_o <= $signed(data_i);
    end
  end
endmodule : mbwch_param_reg
`default_nettype wire

// >>> hw/mbwch_handler.sv
// modbus write command handler: frame decode, checks, commit and reply
`timescale 1ns/1ns
`default_nettype none
`include "mbwch_cfg.svh"
module mbwch_handler import mbwch_pkg::*; #(
  parameter int BUF_DEPTH = `MBWCH_BUF_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] node_id_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_ok_i,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic signed [15:0] load_inertia_ratio_o,
  output logic signed [15:0] jog_operation_speed_o,
  output logic signed [15:0] speed_cmd_accel_time_o,
  output logic signed [15:0] speed_cmd_decel_time_o,
  output logic [31:0] input_contacts_o,
  output logic forward_limit_contact_o,
  output logic emergency_stop_contact_o,
  output logic drive_energise_contact_o
);
  mbwch_state_type state;
  logic [8:0] rx_cnt;
  logic [7:0] node;
  logic [7:0] func;
  logic [15:0] start_addr;
  logic [15:0] qty;
  logic [7:0] byte_cnt;
  logic [7:0] data_mem [BUF_DEPTH];
  logic [8:0] data_len;
  logic overflow;
  logic [7:0] exc;
  logic [15:0] idx;
  logic [15:0] last_idx;
  logic [2:0] tx_pos;
  logic [8:0] data_pos;
  logic [8:0] data_idx;
  logic data_take;
  logic [7:0] next_exc;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic reg_wr;
  logic [3:0] hits;
  logic any_hit;
  logic is_coil;
  logic unicast;
  logic frame_ok;
  logic [15:0] coil_bytes;
  logic [16:0] coil_end;
  logic [4:0] coil_bit;
  logic [2:0] reply_len;
  logic [7:0] reply_byte;
  logic tx_done;
  localparam logic [31:0] RSVD_MASK = `MBWCH_COIL_RSVD_MASK;
  ////////////////////////////////////////////////////////////////////////
  // frame decode
  assign is_coil = (func == `MBWCH_FC_WR_COILS);
  assign unicast = (node != `MBWCH_BROADCAST);
  assign data_pos = (func == `MBWCH_FC_WR_SINGLE) ?
                    `MBWCH_SINGLE_DATA_POS : `MBWCH_MULTI_DATA_POS;
  assign data_idx = rx_cnt - data_pos;
  assign data_take = rx_valid_i && (state == MBWCH_ST_RECV) &&
                     (rx_cnt >= data_pos) && (rx_cnt > 9'h001);
  // broadcast is obeyed but never answered
  assign frame_ok = rx_crc_ok_i && (rx_cnt > 9'h001) &&
                    (node == node_id_i || node == `MBWCH_BROADCAST);
  assign coil_bytes = (qty + 16'h0007) >> 3;
  assign coil_end = {1'b0, start_addr} + {1'b0, qty};

  // header fields and data capture while receiving
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_cnt <= 9'h000;
      node <= 8'h00;
      func <= 8'h00;
      start_addr <= 16'h0000;
      qty <= 16'h0000;
      byte_cnt <= 8'h00;
      data_len <= 9'h000;
      overflow <= 1'b0;
    end else if (state == MBWCH_ST_RECV) begin
      if (rx_end_i) begin
        rx_cnt <= 9'h000;
      end else if (rx_valid_i) begin
        // counter saturates so a runaway frame stays flagged
        if (rx_cnt != 9'h1ff) begin
          rx_cnt <= rx_cnt + 9'h001;
        end
        case (rx_cnt)
          9'h000: begin
            node <= rx_byte_i;
            data_len <= 9'h000;
            overflow <= 1'b0;
            byte_cnt <= 8'h00;
          end
          9'h001: func <= rx_byte_i;
          9'h002: start_addr[15:8] <= rx_byte_i;
          9'h003: start_addr[7:0] <= rx_byte_i;
          9'h004: qty[15:8] <= rx_byte_i;
          9'h005: qty[7:0] <= rx_byte_i;
          9'h006: byte_cnt <= rx_byte_i;
          default: ;
        endcase
        if (data_take) begin
          if (data_idx < 9'(BUF_DEPTH)) begin
            data_len <= data_len + 9'h001;
          end else begin
            overflow <= 1'b1;
          end
        end
      end
    end
  end

  // data buffer, high byte of each word lands first
  always_ff @(posedge ref_clk_i) begin
    if (data_take && data_idx < 9'(BUF_DEPTH)) begin
      data_mem[data_idx[7:0]] <= rx_byte_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // request checks at the end of a frame
  always_comb begin
    next_exc = `MBWCH_EXC_NONE;
    case (func)
      `MBWCH_FC_WR_SINGLE: begin
        if (rx_cnt != `MBWCH_SINGLE_FRAME_LEN ||
            data_len != `MBWCH_SINGLE_DATA_LEN) begin
          next_exc = `MBWCH_EXC_VALUE;
        end
      end
      `MBWCH_FC_WR_COILS: begin
        if (rx_cnt < `MBWCH_MULTI_DATA_POS || overflow ||
            qty == 16'h0000 || qty > `MBWCH_MAX_COILS ||
            {8'h00, byte_cnt} != coil_bytes ||
            data_len != {1'b0, byte_cnt}) begin
          next_exc = `MBWCH_EXC_VALUE;
        end else if (coil_end > `MBWCH_COIL_COUNT) begin
          next_exc = `MBWCH_EXC_ADDR;
        end
      end
      `MBWCH_FC_WR_REGS: begin
        if (rx_cnt < `MBWCH_MULTI_DATA_POS || overflow ||
            qty == 16'h0000 || qty > `MBWCH_MAX_REGS ||
            {8'h00, byte_cnt} != {qty[14:0], 1'b0} ||
            data_len != {1'b0, byte_cnt}) begin
          next_exc = `MBWCH_EXC_VALUE;
        end
      end
      default: next_exc = `MBWCH_EXC_FUNC;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // sequencing: every address is checked before any word is written,
  // so a failing multi-word request leaves all parameters untouched
  assign tx_done = tx_valid_o && tx_ready_i && tx_last_o;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= MBWCH_ST_RECV;
      exc <= `MBWCH_EXC_NONE;
      idx <= 16'h0000;
      last_idx <= 16'h0000;
    end else begin
      case (state)
        MBWCH_ST_RECV: begin
          if (rx_end_i && frame_ok) begin
            exc <= next_exc;
            idx <= 16'h0000;
            // a single write covers one register, a multi write qty registers or qty coils
            last_idx <= (func == `MBWCH_FC_WR_SINGLE) ?
                        16'h0000 : qty - 16'h0001;
            if (next_exc != `MBWCH_EXC_NONE) begin
              state <= unicast ? MBWCH_ST_REPLY : MBWCH_ST_RECV;
            end else if (is_coil) begin
              state <= MBWCH_ST_COMMIT;
            end else begin
              state <= MBWCH_ST_CHECK;
            end
          end
        end
        MBWCH_ST_CHECK: begin
          if (!any_hit) begin
            exc <= `MBWCH_EXC_ADDR;
            state <= unicast ? MBWCH_ST_REPLY : MBWCH_ST_RECV;
          end else if (idx == last_idx) begin
            idx <= 16'h0000;
            state <= MBWCH_ST_COMMIT;
          end else begin
            idx <= idx + 16'h0001;
          end
        end
        MBWCH_ST_COMMIT: begin
          if (idx == last_idx) begin
            state <= unicast ? MBWCH_ST_REPLY : MBWCH_ST_RECV;
          end else begin
            idx <= idx + 16'h0001;
          end
        end
        MBWCH_ST_REPLY: begin
          if (tx_done) begin
            state <= MBWCH_ST_RECV;
          end
        end
        default: state <= MBWCH_ST_RECV;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // parameter registers
  assign wr_addr = start_addr + idx;
  assign wr_data = {data_mem[{idx[6:0], 1'b0}],
                    data_mem[{idx[6:0], 1'b1}]};
  assign reg_wr = (state == MBWCH_ST_COMMIT) && !is_coil;
  assign any_hit = |hits;

  mbwch_param_reg #(.ADDR(`MBWCH_ADDR_INERTIA)) u_inertia (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(wr_addr),
    .wr_i(reg_wr), .data_i(wr_data), .hit_o(hits[0]),
    .value_o(load_inertia_ratio_o)
  );
  mbwch_param_reg #(.ADDR(`MBWCH_ADDR_JOG)) u_jog (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(wr_addr),
    .wr_i(reg_wr), .data_i(wr_data), .hit_o(hits[1]),
    .value_o(jog_operation_speed_o)
  );
  mbwch_param_reg #(.ADDR(`MBWCH_ADDR_ACCEL)) u_accel (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(wr_addr),
    .wr_i(reg_wr), .data_i(wr_data), .hit_o(hits[2]),
    .value_o(speed_cmd_accel_time_o)
  );
  mbwch_param_reg #(.ADDR(`MBWCH_ADDR_DECEL)) u_decel (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(wr_addr),
    .wr_i(reg_wr), .data_i(wr_data), .hit_o(hits[3]),
    .value_o(speed_cmd_decel_time_o)
  );
  ////////////////////////////////////////////////////////////////////////
  // input contact map, one contact per cycle; range checked beforehand
  assign coil_bit = wr_addr[4:0];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      input_contacts_o <= 32'h0000_0000;
    end else if (state == MBWCH_ST_COMMIT && is_coil) begin
      // reserved contacts stay off whatever is written
      if (!RSVD_MASK[coil_bit]) begin
        input_contacts_o[coil_bit] <=
          data_mem[idx[7:3]][idx[2:0]];
      end
    end
  end

  assign forward_limit_contact_o = input_contacts_o[`MBWCH_POS_FWD];
  assign emergency_stop_contact_o = input_contacts_o[`MBWCH_POS_STOP];
  assign drive_energise_contact_o = input_contacts_o[`MBWCH_POS_SERVO];
  ////////////////////////////////////////////////////////////////////////
  // reply: the six header bytes double as echo and acknowledge
  assign reply_len = (exc != `MBWCH_EXC_NONE) ?
                     `MBWCH_EXC_LEN : `MBWCH_ACK_LEN;

  always_comb begin
    case (tx_pos)
      3'h0: reply_byte = node;
      3'h1: reply_byte = (exc != `MBWCH_EXC_NONE) ?
                         (func | `MBWCH_EXC_FLAG) : func;
      3'h2: reply_byte = (exc != `MBWCH_EXC_NONE) ?
                         exc : start_addr[15:8];
      3'h3: reply_byte = start_addr[7:0];
      3'h4: reply_byte = qty[15:8];
      default: reply_byte = qty[7:0];
    endcase
  end

  // byte sender with ready back-pressure
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_pos <= 3'h0;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
      tx_byte_o <= 8'h00;
    end else if (state != MBWCH_ST_REPLY || tx_done) begin
      tx_pos <= 3'h0;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
    end else if (!tx_valid_o || tx_ready_i) begin
      tx_valid_o <= 1'b1;
      tx_byte_o <= reply_byte;
      tx_last_o <= (tx_pos == reply_len - 3'h1);
      tx_pos <= tx_pos + 3'h1;
    end
  end
endmodule : mbwch_handler
`default_nettype wire

// >>> tb/mbwch_handler_props.sv
// port assertions for the write command handler
`timescale 1ns/1ns
`default_nettype none
module mbwch_handler_props (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic signed [15:0] load_inertia_ratio_o,
  input wire logic [31:0] input_contacts_o,
  input wire logic forward_limit_contact_o,
  input wire logic emergency_stop_contact_o,
  input wire logic drive_energise_contact_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // reply handshake steps
  sequence s_stalled;
    tx_valid_o && !tx_ready_i;
  endsequence
  sequence s_last_taken;
    tx_valid_o && tx_ready_i && tx_last_o;
  endsequence
  a_offer_holds: assert property (
    s_stalled |=> tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
    else $error("reply byte changed while stalled");
  a_reply_ends: assert property (s_last_taken |=> !tx_valid_o)
    else $error("reply runs past its last byte");
  a_answer_delay: assert property (
    rx_end_i && rx_crc_ok_i |=> !tx_valid_o)
    else $error("reply before the frame was checked");
  ////////////////////////////////////////////////////////////////////////////
  // contact map and parameter stability
  a_rsvd_zero: assert property (
    !input_contacts_o[9] && !input_contacts_o[31])
    else $error("reserved contact set");
  a_limit_map: assert property (
    forward_limit_contact_o == input_contacts_o[0])
    else $error("limit contact off its map bit");
  a_stop_map: assert property (
    emergency_stop_contact_o == input_contacts_o[10])
    else $error("stop contact off its map bit");
  a_energise_map: assert property (
    drive_energise_contact_o == input_contacts_o[12])
    else $error("energise contact off its map bit");
  // writes land before the reply, never during it
  a_params_hold: assert property (
    tx_valid_o && $past(tx_valid_o) |-> $stable(load_inertia_ratio_o))
    else $error("parameter moved during reply");
  a_contacts_hold: assert property (
    tx_valid_o && $past(tx_valid_o) |-> $stable(input_contacts_o))
    else $error("contacts moved during reply");
endmodule : mbwch_handler_props
bind mbwch_handler mbwch_handler_props u_mbwch_handler_props (
  .ref_clk_i, .rst_n_i, .rx_end_i, .rx_crc_ok_i, .tx_byte_o, .tx_valid_o,
  .tx_last_o, .tx_ready_i, .load_inertia_ratio_o, .input_contacts_o,
  .forward_limit_contact_o, .emergency_stop_contact_o,
  .drive_energise_contact_o
);
`default_nettype wire

// >>> tb/mbwch_master_model.sv
// master side model: issues request frames and drains replies
`timescale 1ns/1ns
`default_nettype none
module mbwch_master_model (
  input wire logic clk_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  output logic rx_crc_ok_o,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  logic [7:0] rsp[$];
  // idle line at time zero
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
    rx_crc_ok_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // most significant byte first, so words go high byte first
  task automatic send(input logic [103:0] f, input int n, input bit c);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk_i);
      rx_byte_o <= f[8*i +: 8];
      rx_valid_o <= 1'b1;
    end
    @(negedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o; // no stale byte left on the bus
    rx_end_o <= 1'b1;
    rx_crc_ok_o <= c;
    @(negedge clk_i);
    rx_end_o <= 1'b0;
    rx_crc_ok_o <= ~c;
  endtask : send
  // slow mode toggles ready so reply bytes meet stalls
  task automatic take(input bit slow, input int lim, output logic done);
    logic r;
    rsp.delete();
    done = 1'b0;
    for (int k = 0; k < lim && !done; k++) begin
      @(negedge clk_i);
      r = slow ? ~tx_ready_o : 1'b1;
      tx_ready_o <= r;
      if (tx_valid_i && r) begin
        rsp.push_back(tx_byte_i);
        done = tx_last_i;
      end
    end
  endtask : take
endmodule : mbwch_master_model
`default_nettype wire

// >>> tb/test_mbwch_handler.sv
// self-checking bench of the write command handler
`timescale 1ns/1ns
`default_nettype none
module test_mbwch_handler;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] node_id_i = 8'h01;
  logic [7:0] rx_byte_i, tx_byte_o;
  logic rx_valid_i, rx_end_i, rx_crc_ok_i, tx_ready_i, tx_valid_o, tx_last_o;
  logic signed [15:0] load_inertia_ratio_o, jog_operation_speed_o;
  logic signed [15:0] speed_cmd_accel_time_o, speed_cmd_decel_time_o;
  logic [31:0] input_contacts_o;
  logic forward_limit_contact_o, emergency_stop_contact_o;
  logic drive_energise_contact_o;
  int errors = 0;
  int checks = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  mbwch_handler u_mbwch_handler (
    .ref_clk_i, .rst_n_i, .node_id_i, .rx_byte_i, .rx_valid_i, .rx_end_i,
    .rx_crc_ok_i, .tx_byte_o, .tx_valid_o, .tx_last_o, .tx_ready_i,
    .load_inertia_ratio_o, .jog_operation_speed_o, .speed_cmd_accel_time_o,
    .speed_cmd_decel_time_o, .input_contacts_o, .forward_limit_contact_o,
    .emergency_stop_contact_o, .drive_energise_contact_o
  );
  mbwch_master_model u_mbwch_master_model (
    .clk_i(ref_clk_i), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i),
    .rx_end_o(rx_end_i), .rx_crc_ok_o(rx_crc_ok_i), .tx_byte_i(tx_byte_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // one request, reply compared byte for byte; silence expected if ne is 0
  task automatic xfer(input logic [103:0] f, input int nf,
                      input logic [47:0] e, input int ne, input bit c,
                      input bit slow);
    logic ok;
    u_mbwch_master_model.send(f, nf, c);
    u_mbwch_master_model.take(slow, (ne > 0) ? 400 : 30, ok);
    check({31'h0, ok}, (ne > 0) ? 32'h1 : 32'h0);
    if (ne > 0 && !ok) begin
      results();
    end else begin
      check(u_mbwch_master_model.rsp.size(), ne);
      for (int i = 0; i < ne; i++) begin
        check(u_mbwch_master_model.rsp[i], e[8*(ne-1-i) +: 8]);
      end
    end
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check({load_inertia_ratio_o, jog_operation_speed_o}, 32'h0);
    check({speed_cmd_accel_time_o, speed_cmd_decel_time_o}, 32'h0);
    check(input_contacts_o, 32'h00000000);
  endtask : t_reset
  task automatic t_single;
    xfer(48'h0106210000c8, 6, 48'h0106210000c8, 6, 1, 1);
    check({load_inertia_ratio_o}, 32'h000000c8);
  endtask : t_single
  task automatic t_coils;
    xfer(72'h010f0000000b020104, 9, 48'h010f0000000b, 6, 1, 0);
    check(input_contacts_o, 32'h00000401);
    check({forward_limit_contact_o, emergency_stop_contact_o}, 2'h3);
    xfer(64'h010f00080005011f, 8, 48'h010f00080005, 6, 1, 1);
    check(input_contacts_o, 32'h00001d01);
    check({drive_energise_contact_o}, 32'h1);
    xfer(88'h010f0000002004ffffffff, 11, 48'h010f00000020, 6, 1, 0);
    check(input_contacts_o, 32'h7ffffdff);
  endtask : t_coils
  task automatic t_regs;
    xfer(104'h01102300000306f44800640064, 13,
         48'h011023000003, 6, 1, 1);
    // signed output widens with its sign: -3000
    check(jog_operation_speed_o, 32'hfffff448);
    check({speed_cmd_accel_time_o}, 32'h00000064);
    check({speed_cmd_decel_time_o}, 32'h00000064);
    xfer(72'h01102302000102ffff, 9, 48'h011023020001, 6, 1, 0);
    check({speed_cmd_decel_time_o}, 32'h0000ffff);
  endtask : t_regs
  // every refusal leaves the parameters as they were
  task automatic t_exc;
    xfer(48'h010321000001, 6, 24'h018301, 3, 1, 1);
    xfer(88'h0110230200020400090009, 11, 24'h019002, 3, 1, 0);
    check({speed_cmd_decel_time_o}, 32'h0000ffff);
    xfer(80'h01102300000103000100, 10, 24'h019003, 3, 1, 0);
    xfer(64'h010f001e0004010f, 8, 24'h018f02, 3, 1, 1);
    xfer(48'h010640000001, 6, 24'h018602, 3, 1, 0);
  endtask : t_exc
  // bad check sum and foreign node stay silent; broadcast acts silently
  task automatic t_drop;
    xfer(48'h010623020007, 6, 48'h0, 0, 0, 0);
    xfer(48'h020623020007, 6, 48'h0, 0, 1, 0);
    check({speed_cmd_decel_time_o}, 32'h0000ffff);
    xfer(48'h000623020007, 6, 48'h0, 0, 1, 0);
    check({speed_cmd_decel_time_o}, 32'h00000007);
  endtask : t_drop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_single();
    t_coils();
    t_regs();
    t_exc();
    t_drop();
    results();
  end
endmodule : test_mbwch_handler
`default_nettype wire
